// ---- sio_status_io.sv ----
// Operation
// R1 - a terminal set to no function drives nothing and ignores its input
// R2 - total output active when forward total reaches the two-part threshold
// R3 - flow at or below low limit or at or above high limit flags
// R4 - flow at or below low-low or at or above high-high flags
// R5 - high-high/low-low counts as alarm only when its enable is set
// R6 - reverse flow selects reverse range and drives terminal active
// R7 - flow above full scale steps to next range, terminal follows range
// R8 - three or four range mode takes both terminals for the range code
// R9 - answerback shows which of two externally chosen ranges is in use
// R10 - signal lock forces zero flow and halts totalizing and pulses
// R11 - signal lock overrides the alarm output level
// R12 - on lock release flow indication returns through the damping filter
// R13 - auto-zero input starts a zero adjustment
// R14 - preset input loads two-part preset or zero into the total
// R15 - total execution start resumes counting from the preset
// R16 - external two-range input picks the forward range only
// R17 - closed-active closes contact when active, open-active inverts
// R18 - pulse mode closes contact during each pulse
// R19 - shorted input requests action, reversed under inverted polarity
// R20 - the contact input is synchronised and debounced before use
//
// Decided for this implementation: register access over APB and the register offsets.
`timescale 1ns/1ps
module sio_status_io #(
    parameter int DEB_CYCLES = sio_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic                                ref_clk,
    input  wire logic                                rstn,
    // apb slave
    input  wire logic                                psel,
    input  wire logic                                penable,
    input  wire logic                                pwrite,
    input  wire logic [7:0]                          paddr,
    input  wire logic [31:0]                         pwdata,
    output logic      [31:0]                         prdata,
    output logic                                     pready,
    output logic                                     pslverr,
    // measurement inputs
    input  wire logic signed [sio_pkg::FLOW_W-1:0]   flow_value,
    input  wire logic [sio_pkg::TOT_W-1:0]           fwd_total,
    input  wire logic                                alarm_in,
    input  wire logic                                warning_in,
    input  wire logic                                pulse_in,
    // status terminals
    output logic                                     do_pin_o,
    input  wire logic                                bidir_i,
    output logic                                     bidir_o,
    output logic                                     bidir_oe,
    // commands to the transmitter core
    output logic signed [sio_pkg::FLOW_W-1:0]        flow_ind_o,
    output logic                                     lock_o,
    output logic                                     burnout_o,
    output logic                                     auto_zero_o,
    output logic                                     fwd_preset_o,
    output logic                                     rev_preset_o,
    output logic      [sio_pkg::TOT_W-1:0]           preset_value_o,
    output logic                                     preset_zero_o,
    output logic                                     count_resume_o,
    output logic      [1:0]                          range_o,
    output logic                                     reverse_o
);

    localparam int FW = sio_pkg::FLOW_W;
    localparam int HW = sio_pkg::HALF_W;

    logic [sio_pkg::CTRL_BITS-1:0] ctrl_reg;
    logic [31:0]                   thr_reg;
    logic [31:0]                   lim_reg;
    logic [31:0]                   xlim_reg;
    logic [31:0]                   pre_reg;
    logic [31:0]                   span_reg [0:1];
    logic [3:0]                    damp_reg;
    logic [31:0]                   prdata_reg;
    logic [1:0]                    range_reg;
    logic                          rev_reg;
    logic                          do_reg;
    logic                          bo_reg;
    logic                          boe_reg;
    logic                          in_act_prev_reg;
    logic                          az_reg;
    logic                          fpre_reg;
    logic                          rpre_reg;
    logic signed [FW-1:0]          ind_reg;
    sio_filter_if                  filt_if ();

    // output pattern from active state and polarity
    function automatic logic drive(input logic act, input logic open_act);
        return act ^ open_act;
    endfunction

    // flow outside a low/high pair, both ends inclusive
    function automatic logic outside(input logic signed [FW-1:0] v,
                                     input logic [31:0] lims);
        return (v <= $signed(lims[HW-1:0])) || (v >= $signed(lims[31:HW]));
    endfunction

    // register select
    function automatic logic mapped(input logic [7:0] a);
        return a <= sio_pkg::STAT_OFS && a[1:0] == 2'b00;
    endfunction

    // decoded configuration
    sio_pkg::sio_func_type out_fn;
    sio_pkg::sio_func_type bid_raw;
    sio_pkg::sio_func_type bid_fn;
    logic out_pol;
    logic bid_pol;
    assign out_fn  = sio_pkg::sio_func_type'(
                         ctrl_reg[sio_pkg::CTRL_OUTF +: 5]);
    assign bid_raw = sio_pkg::sio_func_type'(
                         ctrl_reg[sio_pkg::CTRL_BIDF +: 5]);
    assign out_pol = ctrl_reg[sio_pkg::CTRL_OPOL];
    assign bid_pol = ctrl_reg[sio_pkg::CTRL_BPOL];

    // three or four range mode takes the bidir terminal as well
    always_comb begin
        bid_fn = bid_raw;
        if (out_fn == sio_pkg::FN_AUTO3 || out_fn == sio_pkg::FN_AUTO4) begin
            bid_fn = out_fn; // [R8]
        end else if (bid_raw == sio_pkg::FN_AUTO3 ||
                     bid_raw == sio_pkg::FN_AUTO4 ||
                     bid_raw == sio_pkg::FN_PULSE) begin
            bid_fn = sio_pkg::FN_NONE;
        end
    end

    // apb slave, zero wait states
    logic wr_en;
    assign wr_en   = psel && penable && pwrite;
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped(paddr);
    assign prdata  = prdata_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ctrl_reg    <= sio_pkg::CTRL_RST[sio_pkg::CTRL_BITS-1:0];
            thr_reg     <= sio_pkg::LIM_RST;
            lim_reg     <= sio_pkg::LIM_RST;
            xlim_reg    <= sio_pkg::LIM_RST;
            pre_reg     <= sio_pkg::LIM_RST;
            span_reg[0] <= sio_pkg::SPAN_RST;
            span_reg[1] <= sio_pkg::SPAN_RST;
            damp_reg    <= sio_pkg::DAMP_RST;
        end else if (wr_en) begin
            case (paddr)
                sio_pkg::CTRL_OFS: ctrl_reg <= pwdata[sio_pkg::CTRL_BITS-1:0];
                sio_pkg::THR_LO:   thr_reg[HW-1:0] <= pwdata[HW-1:0]; // [R2]
                sio_pkg::THR_HI:   thr_reg[31:HW]  <= pwdata[HW-1:0];
                sio_pkg::LIM_OFS:  lim_reg  <= pwdata;
                sio_pkg::XLIM_OFS: xlim_reg <= pwdata;
                sio_pkg::PRE_LO:   pre_reg[HW-1:0] <= pwdata[HW-1:0]; // [R14]
                sio_pkg::PRE_HI:   pre_reg[31:HW]  <= pwdata[HW-1:0];
                sio_pkg::SPAN_A:   span_reg[0] <= pwdata;
                sio_pkg::SPAN_B:   span_reg[1] <= pwdata;
                sio_pkg::DAMP_OFS: damp_reg <= pwdata[3:0];
                default: ;
            endcase
        end
    end

    // read data captured in the setup cycle
    logic [31:0] rd_mux;
    logic [31:0] stat_word;
    assign stat_word = {24'h000000, alarm_in & ~lock_o,
                        filt_if.level ^ bid_pol, bidir_o, do_pin_o,
                        lock_o, rev_reg, range_reg};
    always_comb begin
        case (paddr)
            sio_pkg::CTRL_OFS: rd_mux = {11'h000, ctrl_reg};
            sio_pkg::THR_LO:   rd_mux = {16'h0000, thr_reg[HW-1:0]};
            sio_pkg::THR_HI:   rd_mux = {16'h0000, thr_reg[31:HW]};
            sio_pkg::LIM_OFS:  rd_mux = lim_reg;
            sio_pkg::XLIM_OFS: rd_mux = xlim_reg;
            sio_pkg::PRE_LO:   rd_mux = {16'h0000, pre_reg[HW-1:0]};
            sio_pkg::PRE_HI:   rd_mux = {16'h0000, pre_reg[31:HW]};
            sio_pkg::SPAN_A:   rd_mux = span_reg[0];
            sio_pkg::SPAN_B:   rd_mux = span_reg[1];
            sio_pkg::DAMP_OFS: rd_mux = {28'h0000000, damp_reg};
            sio_pkg::STAT_OFS: rd_mux = stat_word;
            default:           rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            prdata_reg <= 32'h0000_0000;
        end else if (psel && !penable) begin
            prdata_reg <= rd_mux;
        end
    end

    // contact input conditioning
    assign filt_if.raw = bidir_i;
    sio_debounce #(.DEB_CYCLES(DEB_CYCLES)) u_deb (
        .ref_clk (ref_clk),
        .rstn    (rstn),
        .f       (filt_if)
    ); // [R20]

    // short means request; inverted polarity swaps it
    logic in_act;
    logic in_rise;
    assign in_act  = filt_if.level ^ bid_pol; // [R19]
    assign in_rise = in_act && !in_act_prev_reg;

    // per-function input requests, ignored unless selected
    logic lock_act;
    assign lock_act = (bid_fn == sio_pkg::FN_LOCK) && in_act; // [R1] [R10]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            in_act_prev_reg <= 1'b0;
            az_reg          <= 1'b0;
            fpre_reg        <= 1'b0;
            rpre_reg        <= 1'b0;
        end else begin
            in_act_prev_reg <= in_act;
            az_reg   <= in_rise && bid_fn == sio_pkg::FN_AZERO;   // [R13]
            fpre_reg <= in_rise && bid_fn == sio_pkg::FN_FPRESET; // [R14]
            rpre_reg <= in_rise && bid_fn == sio_pkg::FN_RPRESET;
        end
    end

    assign auto_zero_o    = az_reg;
    assign fwd_preset_o   = fpre_reg;
    assign rev_preset_o   = rpre_reg;
    assign preset_value_o = pre_reg;
    assign preset_zero_o  = ctrl_reg[sio_pkg::CTRL_ZERO];
    assign count_resume_o = ctrl_reg[sio_pkg::CTRL_EXEC]; // [R15]

    // range selection
    logic [FW-1:0] mag;
    logic [1:0]    max_idx;
    logic [FW-1:0] span_cur;
    logic [FW-1:0] span_low;
    logic          fwdrev_on;
    logic          ext2_on;
    logic [1:0]    range_next;
    assign mag       = flow_value[FW-1] ? FW'(-flow_value) : flow_value;
    assign fwdrev_on = out_fn == sio_pkg::FN_FWDREV
                       || bid_fn == sio_pkg::FN_FWDREV;
    assign ext2_on   = bid_fn == sio_pkg::FN_EXT2;
    assign span_cur  = range_reg[1] ? span_reg[1][range_reg[0]*HW +: HW]
                                    : span_reg[0][range_reg[0]*HW +: HW];
    assign span_low  = range_reg[1] ? (range_reg[0] ? span_reg[1][0 +: HW]
                                                    : span_reg[0][HW +: HW])
                                    : span_reg[0][0 +: HW];

    always_comb begin
        if (out_fn == sio_pkg::FN_AUTO4) begin
            max_idx = 2'd3;
        end else if (out_fn == sio_pkg::FN_AUTO3) begin
            max_idx = 2'd2;
        end else if (out_fn == sio_pkg::FN_AUTO2
                     || bid_fn == sio_pkg::FN_AUTO2) begin
            max_idx = 2'd1;
        end else begin
            max_idx = 2'd0;
        end
        range_next = range_reg;
        if (ext2_on) begin
            range_next = {1'b0, in_act}; // [R16]
        end else if (range_reg > max_idx) begin
            range_next = max_idx;
        end else if (range_reg < max_idx && mag > span_cur) begin
            range_next = range_reg + 2'd1; // [R7]
        end else if (range_reg != 2'd0 && mag < span_low) begin
            range_next = range_reg - 2'd1;
        end
    end

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            range_reg <= 2'd0;
            rev_reg   <= 1'b0;
        end else begin
            range_reg <= range_next;
            rev_reg   <= fwdrev_on && flow_value < 0; // [R6]
        end
    end

    assign range_o   = range_reg;
    assign reverse_o = rev_reg;

    // active state per function code
    logic [31:0] cond;
    always_comb begin
        cond = 32'h0000_0000;
        cond[sio_pkg::FN_PULSE]  = pulse_in && !lock_act; // [R10] [R18]
        cond[sio_pkg::FN_ALARM]  = alarm_in;
        cond[sio_pkg::FN_WARN]   = warning_in;
        cond[sio_pkg::FN_TOTAL]  = fwd_total >= thr_reg; // [R2]
        cond[sio_pkg::FN_HL]     = outside(flow_value, lim_reg); // [R3]
        cond[sio_pkg::FN_HHLL]   = outside(flow_value, xlim_reg) // [R4]
                                   && ctrl_reg[sio_pkg::CTRL_XEN]; // [R5]
        cond[sio_pkg::FN_FWDREV] = rev_reg; // [R6]
        cond[sio_pkg::FN_AUTO2]  = range_reg[0]; // [R7]
        cond[sio_pkg::FN_AUTO3]  = range_reg[0];
        cond[sio_pkg::FN_AUTO4]  = range_reg[0];
        cond[sio_pkg::FN_ANSWER] = range_reg[0] && ext2_on; // [R9]
    end

    // terminal drivers; idle terminal stays open
    logic do_next;
    logic bid_out_fn;
    logic bid_act;
    assign bid_out_fn = bid_fn != sio_pkg::FN_NONE && bid_fn < sio_pkg::FN_LOCK;
    assign bid_act    = (bid_fn == sio_pkg::FN_AUTO3
                         || bid_fn == sio_pkg::FN_AUTO4) ? range_reg[1]
                                                         : cond[bid_fn];
    assign do_next    = (out_fn == sio_pkg::FN_NONE
                         || out_fn >= sio_pkg::FN_LOCK)
                        ? 1'b0 : drive(cond[out_fn], out_pol); // [R1] [R17]

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            do_reg  <= 1'b0;
            bo_reg  <= 1'b0;
            boe_reg <= 1'b0;
        end else begin
            do_reg  <= do_next;
            bo_reg  <= bid_out_fn && drive(bid_act, bid_pol); // [R17]
            boe_reg <= bid_out_fn; // [R1] [R8]
        end
    end

    assign do_pin_o = do_reg;
    assign bidir_o  = bo_reg;
    assign bidir_oe = boe_reg;

    // flow indication, damped toward measured value or forced to zero
    logic signed [FW:0] diff;
    logic signed [FW:0] step;
    assign diff = $signed({flow_value[FW-1], flow_value})
                  - $signed({ind_reg[FW-1], ind_reg});
    assign step = diff >>> damp_reg;

    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            ind_reg <= '0;
        end else if (lock_act) begin
            ind_reg <= '0; // [R10]
        end else if (step == 0) begin
            ind_reg <= flow_value;
        end else begin
            ind_reg <= FW'(ind_reg + step[FW-1:0]); // [R12]
        end
    end

    assign flow_ind_o = ind_reg;
    assign lock_o     = lock_act; // [R10]
    assign burnout_o  = alarm_in && !lock_act; // [R11]

    // checks
    property p_none_do;
        @(posedge ref_clk) disable iff (!rstn)
        out_fn == sio_pkg::FN_NONE |=> !do_pin_o;
    endproperty
    a_none_do: assert property (p_none_do) else $error("do driven"); // [R1]

    property p_total;
        @(posedge ref_clk) disable iff (!rstn)
        out_fn == sio_pkg::FN_TOTAL |=> do_pin_o ==
            (($past(fwd_total) >= $past(thr_reg)) ^ $past(out_pol));
    endproperty
    a_total: assert property (p_total) else $error("total wrong"); // [R2]

    property p_hl;
        @(posedge ref_clk) disable iff (!rstn)
        out_fn == sio_pkg::FN_HL && !out_pol
        && flow_value <= $signed(lim_reg[HW-1:0]) |=> do_pin_o;
    endproperty
    a_hl: assert property (p_hl) else $error("low limit missed"); // [R3]

    property p_hhll;
        @(posedge ref_clk) disable iff (!rstn)
        out_fn == sio_pkg::FN_HHLL && !out_pol
        && flow_value >= $signed(xlim_reg[31:HW])
        |=> do_pin_o == $past(ctrl_reg[sio_pkg::CTRL_XEN]);
    endproperty
    a_hhll: assert property (p_hhll) else $error("hhll wrong"); // [R5]

    property p_rev;
        @(posedge ref_clk) disable iff (!rstn)
        fwdrev_on && flow_value < 0 |=> reverse_o;
    endproperty
    a_rev: assert property (p_rev) else $error("reverse not seen"); // [R6]

    property p_range_up;
        @(posedge ref_clk) disable iff (!rstn)
        !ext2_on && range_reg < max_idx && mag > span_cur
        |=> range_o == $past(range_reg) + 2'd1;
    endproperty
    a_range_up: assert property (p_range_up) else $error("no step up"); // [R7]

    property p_lock;
        @(posedge ref_clk) disable iff (!rstn)
        lock_act |-> !burnout_o ##1 flow_ind_o == 0;
    endproperty
    a_lock: assert property (p_lock) else $error("lock not held"); // [R10]

    property p_pulse;
        @(posedge ref_clk) disable iff (!rstn)
        out_fn == sio_pkg::FN_PULSE && !lock_act
        |=> do_pin_o == ($past(pulse_in) ^ $past(out_pol));
    endproperty
    a_pulse: assert property (p_pulse) else $error("pulse mismatch"); // [R18]

    property p_in_ignored;
        @(posedge ref_clk) disable iff (!rstn)
        bid_fn == sio_pkg::FN_NONE |=> !auto_zero_o && !bidir_oe;
    endproperty
    a_in_ignored: assert property (p_in_ignored) // [R1]
        else $error("idle bidir acted");

    c_lock:   cover property (@(posedge ref_clk) disable iff (!rstn)
                              lock_act ##1 !lock_act);
    c_range:  cover property (@(posedge ref_clk) disable iff (!rstn)
                              range_reg == 2'd3);
    c_preset: cover property (@(posedge ref_clk) disable iff (!rstn)
                              fwd_preset_o);

endmodule

// ---- sio_pkg.sv ----
package sio_pkg;

    // data widths
    localparam int FLOW_W = 16;
    localparam int TOT_W  = 32;
    localparam int HALF_W = 16;

    // register byte offsets
    localparam logic [7:0] CTRL_OFS  = 8'h00;
    localparam logic [7:0] THR_LO    = 8'h04;
    localparam logic [7:0] THR_HI    = 8'h08;
    localparam logic [7:0] LIM_OFS   = 8'h0c;
    localparam logic [7:0] XLIM_OFS  = 8'h10;
    localparam logic [7:0] PRE_LO    = 8'h14;
    localparam logic [7:0] PRE_HI    = 8'h18;
    localparam logic [7:0] SPAN_A    = 8'h1c;
    localparam logic [7:0] SPAN_B    = 8'h20;
    localparam logic [7:0] DAMP_OFS  = 8'h24;
    localparam logic [7:0] STAT_OFS  = 8'h28;

    // control field positions
    localparam int CTRL_OUTF  = 0;
    localparam int CTRL_BIDF  = 8;
    localparam int CTRL_OPOL  = 16;
    localparam int CTRL_BPOL  = 17;
    localparam int CTRL_XEN   = 18;
    localparam int CTRL_EXEC  = 19;
    localparam int CTRL_ZERO  = 20;
    localparam int CTRL_BITS  = 21;

    // values after reset
    localparam logic [31:0] CTRL_RST = 32'h0000_0000;
    localparam logic [31:0] LIM_RST  = 32'h0000_0000;
    localparam logic [31:0] SPAN_RST = 32'hffff_ffff;
    localparam logic [3:0]  DAMP_RST = 4'h4;

    // contact debounce time
    localparam int CLK_MHZ         = 200;
    localparam int DEBOUNCE_US     = 1000;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_US * CLK_MHZ;
    localparam int DEB_W           = 20;

    // terminal functions
    typedef enum logic [4:0] {
        FN_NONE     = 5'h00,
        FN_PULSE    = 5'h01,
        FN_ALARM    = 5'h02,
        FN_WARN     = 5'h03,
        FN_TOTAL    = 5'h04,
        FN_HL       = 5'h05,
        FN_HHLL     = 5'h06,
        FN_FWDREV   = 5'h07,
        FN_AUTO2    = 5'h08,
        FN_AUTO3    = 5'h09,
        FN_AUTO4    = 5'h0a,
        FN_ANSWER   = 5'h0b,
        FN_LOCK     = 5'h0c,
        FN_AZERO    = 5'h0d,
        FN_FPRESET  = 5'h0e,
        FN_RPRESET  = 5'h0f,
        FN_EXT2     = 5'h10
    } sio_func_type;

endpackage

// ---- sio_filter_if.sv ----
`timescale 1ns/1ps
interface sio_filter_if;
    logic raw;
    logic level;
    logic rise;

    modport filt (input raw, output level, output rise);
    modport user (output raw, input level, input rise);
endinterface

// ---- sio_debounce.sv ----
`timescale 1ns/1ps
module sio_debounce #(
    parameter int DEB_CYCLES = sio_pkg::DEBOUNCE_CYCLES
) (
    // clock and reset
    input  wire logic ref_clk,
    input  wire logic rstn,
    // filtered contact
    sio_filter_if.filt f
);

    logic                       sync1_reg;
    logic                       sync2_reg;
    logic                       level_reg;
    localparam int DW = sio_pkg::DEB_W;

    logic [sio_pkg::DEB_W-1:0]  cnt_reg;

    // two-stage synchroniser for the contact pin
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
        end else begin
            sync1_reg <= f.raw;
            sync2_reg <= sync1_reg;
        end
    end

    // level accepted only after it stays put for the debounce time
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_reg   <= '0;
            level_reg <= 1'b0;
        end else if (sync2_reg == level_reg) begin
            cnt_reg <= '0;
        end else if (cnt_reg >= DW'(DEB_CYCLES - 1)) begin
            cnt_reg   <= '0;
            level_reg <= sync2_reg;
        end else begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    assign f.level = level_reg;
    assign f.rise  = (sync2_reg != level_reg) && !level_reg
                     && (cnt_reg >= DW'(DEB_CYCLES - 1));

endmodule

// ---- sio_field_ctl.sv ----
`timescale 1ns/1ps
module sio_field_ctl (
    // field side contact
    input  wire logic contact_short,
    // terminal drive from the device
    input  wire logic bidir_o,
    input  wire logic bidir_oe,
    // wire level seen by the device
    output logic      bidir_i
);
    // open contact reads 0, a short reads 1, the device drive wins
    assign bidir_i = bidir_oe ? bidir_o : contact_short;
endmodule

// ---- sio_status_io_tb_top.sv ----
`timescale 1ns/1ps
module sio_status_io_tb_top;
    typedef struct packed {
        logic [31:0] c;
        logic [15:0] f;
        logic [31:0] t;
        logic        e;
        logic        x;
    } sio_row_type;
    logic ref_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [7:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, pv, rd;
    logic pready, pslverr, se, ev = 0, sh = 0, bi, bo, boe, dpin;
    logic signed [15:0] flow = 0, find;
    logic [31:0] tot = 0;
    logic lk, bur, az, fp, rp, pz, cr, rv;
    logic [1:0] rng;
    int err_total = 0, checked = 0, np;
    sio_row_type rows[16] = '{
        '{32'h0, 16'h01f4, 32'h10, 1'b1, 1'b0},
        '{32'h2, 16'h0, 32'h0, 1'b1, 1'b1},
        '{32'h3, 16'h0, 32'h0, 1'b1, 1'b1},
        '{32'h4, 16'h0, 32'h10, 1'b0, 1'b1},
        '{32'h4, 16'h0, 32'hf, 1'b0, 1'b0},
        '{32'h5, 16'h0064, 32'h0, 1'b0, 1'b1},
        '{32'h5, 16'h0063, 32'h0, 1'b0, 1'b0},
        '{32'h5, 16'hff9c, 32'h0, 1'b0, 1'b1},
        '{32'h40006, 16'h00c8, 32'h0, 1'b0, 1'b1},
        '{32'h40006, 16'hff38, 32'h0, 1'b0, 1'b1},
        '{32'h6, 16'h00c8, 32'h0, 1'b0, 1'b0},
        '{32'h7, 16'hfffb, 32'h0, 1'b0, 1'b1},
        '{32'h7, 16'h0005, 32'h0, 1'b0, 1'b0},
        '{32'h10004, 16'h0, 32'h10, 1'b0, 1'b0},
        '{32'h1, 16'h0, 32'h0, 1'b1, 1'b1},
        '{32'h1, 16'h0, 32'h0, 1'b0, 1'b0}};
    // clock
    always #2.5 ref_clk = ~ref_clk;
    sio_field_ctl FC (.contact_short(sh), .bidir_o(bo), .bidir_oe(boe),
        .bidir_i(bi));
    sio_status_io #(.DEB_CYCLES(4)) DUT (.ref_clk(ref_clk), .rstn(rstn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .flow_value(flow), .fwd_total(tot),
        .alarm_in(ev), .warning_in(ev), .pulse_in(ev), .do_pin_o(dpin),
        .bidir_i(bi), .bidir_o(bo), .bidir_oe(boe), .flow_ind_o(find),
        .lock_o(lk), .burnout_o(bur), .auto_zero_o(az),
        .fwd_preset_o(fp), .rev_preset_o(rp), .preset_value_o(pv),
        .preset_zero_o(pz), .count_resume_o(cr), .range_o(rng),
        .reverse_o(rv));
    // one apb transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge ref_clk);
        penable <= 1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        se = pslverr;
        psel <= 0; penable <= 0;
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        checked++;
        if (g !== e) begin
            err_total++;
            $display("[ERR] %s exp %h got %h", nm, e, g);
        end
    endtask
    // short the contact, count command pulses over a fixed span
    task automatic press(input logic [31:0] c);
        apb(1, sio_pkg::CTRL_OFS, c);
        np = 0;
        sh <= 1;
        repeat (30) begin
            @(posedge ref_clk);
            np += int'(az) + int'(fp) + int'(rp);
        end
        sh <= 0;
        repeat (20) @(posedge ref_clk);
    endtask
    task automatic wrap_up;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // watchdog
    initial begin
        #200000;
        err_total++;
        wrap_up;
    end
    initial begin
        repeat (8) @(posedge ref_clk);
        rstn <= 1;
        apb(0, sio_pkg::SPAN_A, 0); chk("span", 32'hffffffff, rd);
        apb(0, sio_pkg::DAMP_OFS, 0); chk("damp", 32'h4, rd);
        apb(0, 8'h2c, 0); chk("unmapped", 32'h1, {31'h0, se});
        apb(1, sio_pkg::THR_LO, 32'h10);
        apb(1, sio_pkg::LIM_OFS, 32'h0064_ff9c);
        apb(1, sio_pkg::XLIM_OFS, 32'h00c8_ff38);
        apb(1, sio_pkg::PRE_LO, 32'h1234);
        apb(1, sio_pkg::PRE_HI, 32'h5678);
        foreach (rows[i]) begin
            flow <= rows[i].f; tot <= rows[i].t; ev <= rows[i].e;
            apb(1, sio_pkg::CTRL_OFS, rows[i].c);
            repeat (3) @(posedge ref_clk);
            chk("do_pin", {31'h0, rows[i].x}, {31'h0, dpin});
        end
        // automatic ranges, then reverse flow
        apb(1, sio_pkg::SPAN_A, 32'h0200_0100);
        flow <= 16'sh12c;
        apb(1, sio_pkg::CTRL_OFS, 32'h8);
        repeat (3) @(posedge ref_clk);
        chk("rng2", 32'h1, {30'h0, rng});
        chk("rng2_do", 32'h1, {31'h0, dpin});
        flow <= 16'sh300;
        apb(1, sio_pkg::CTRL_OFS, 32'ha);
        repeat (3) @(posedge ref_clk);
        chk("rng4", 32'h2, {30'h0, rng});
        chk("rng4_bidir", 32'h1, {31'h0, bo});
        flow <= 16'shfffb;
        apb(1, sio_pkg::CTRL_OFS, 32'h7);
        repeat (3) @(posedge ref_clk);
        chk("reverse", 32'h1, {31'h0, rv});
        // shorted contact while the terminal has no function
        flow <= 16'sd300; ev <= 1;
        press(32'h0); chk("idle", 32'h0, np);
        // signal lock held, alarm present
        apb(1, sio_pkg::CTRL_OFS, 32'h0c00);
        sh <= 1;
        for (int k = 0; k < 20 && lk !== 1'b1; k++) @(posedge ref_clk);
        repeat (2) @(posedge ref_clk);
        chk("lock", 32'h1, {31'h0, lk});
        chk("flow_ind", 32'h0, {16'h0, find});
        chk("burnout", 32'h0, {31'h0, bur});
        sh <= 0; ev <= 0;
        repeat (20) @(posedge ref_clk);
        chk("damped", 32'h0, {31'h0, find == 16'sh12c});
        // external range input with answerback on the output
        apb(1, sio_pkg::CTRL_OFS, 32'h100b);
        sh <= 1;
        repeat (12) @(posedge ref_clk);
        chk("ext_rng", 32'h1, {30'h0, rng});
        chk("answer", 32'h1, {31'h0, dpin});
        sh <= 0;
        repeat (20) @(posedge ref_clk);
        press(32'h0d00); chk("azero", 32'h1, np);
        press(32'h180e00); chk("fpre", 32'h1, np);
        chk("preval", 32'h5678_1234, pv);
        chk("pzero", 32'h1, {31'h0, pz});
        chk("resume", 32'h1, {31'h0, cr});
        press(32'h0f00); chk("rpre", 32'h1, np);
        chk("settled", 32'h12c, {16'h0, find});
        // alarm on both terminals, then a reset in mid-run
        ev <= 1;
        apb(1, sio_pkg::CTRL_OFS, 32'h0202);
        repeat (3) @(posedge ref_clk);
        chk("bidir_o", 32'h1, {31'h0, bo});
        chk("bidir_oe", 32'h1, {31'h0, boe});
        rstn <= 0;
        repeat (2) @(posedge ref_clk);
        chk("rst_do", 32'h0, {31'h0, dpin});
        rstn <= 1;
        apb(0, sio_pkg::CTRL_OFS, 0); chk("rst_ctrl", 32'h0, rd);
        wrap_up;
    end
endmodule
